// [glk_pkg.sv]
package glk_pkg;

	// ****************************************************************
	// timebase
	// ****************************************************************
	localparam int unsigned CLK_HZ = 32'h017d7840;
	localparam int unsigned MS_PER_S = 32'h000003e8;
	// clock cycles in one millisecond tick
	localparam int unsigned MS_TICK_CYC = CLK_HZ / MS_PER_S;
	localparam int TICK_W = 16;

	// ****************************************************************
	// request timing in milliseconds
	// ****************************************************************
	localparam int MS_W = 10;
	localparam logic [MS_W-1:0] MS_ONE = 10'h001;
	localparam logic [MS_W-1:0] MS_MAX = 10'h3ff;
	// 350 ms and 400 ms pulse width window
	localparam logic [MS_W-1:0] PULSE_MIN_MS = 10'h15e;
	localparam logic [MS_W-1:0] PULSE_MAX_MS = 10'h190;
	// 40 ms to 500 ms directional edge spacing
	localparam logic [MS_W-1:0] DIR_MIN_MS = 10'h028;
	localparam logic [MS_W-1:0] DIR_MAX_MS = 10'h1f4;
	// toggle spacing must stay below 20 ms
	localparam logic [MS_W-1:0] TOGGLE_MAX_MS = 10'h014;
	// 500 ms for requests to follow a bus command
	localparam logic [MS_W-1:0] DIAG_WAIT_MS = 10'h1f4;
	// 100 ms processing time of a request
	localparam logic [MS_W-1:0] PROC_MS = 10'h064;
	// controller side: pulse width, edge offset, pause between requests
	localparam logic [MS_W-1:0] PULSE_NOM_MS = 10'h177;
	localparam logic [MS_W-1:0] DIR_OFFSET_MS = 10'h064;
	localparam logic [MS_W-1:0] GAP_MS = 10'h064;

	// ****************************************************************
	// diagnostic bus commands and status byte
	// ****************************************************************
	localparam logic [7:0] CMD_MODE_NONE = 8'h00;
	localparam logic [7:0] CMD_MODE_PASSIVE = 8'h01;
	localparam logic [7:0] CMD_MODE_ACTIVE = 8'h02;
	localparam logic [7:0] CMD_LOCK = 8'h10;
	localparam logic [7:0] CMD_UNLOCK = 8'h11;
	localparam logic [7:0] CMD_POLL = 8'h20;
	localparam int ST_LOCK = 0;
	localparam int ST_SAFE = 1;
	localparam int ST_AUX = 2;
	localparam int ST_ACT = 3;
	localparam int ST_MODE_LO = 4;
	localparam int ST_MODE_HI = 5;

	typedef enum logic [1:0] {
		MODE_NONE,
		MODE_PASSIVE,
		MODE_ACTIVE
	} glk_mode_t;

endpackage

// [glk_if.sv]
`timescale 1ns/1ps
interface glk_if;
	logic lock_request_ch1;
	logic lock_request_ch2;
	logic safe_out_ch1;
	logic safe_out_ch2;
	logic fieldbus_present;
	logic diag_input_valid;
	logic [7:0] diag_input;
	logic signal_diag_output_valid;
	logic [7:0] signal_diag_output;

	modport dev (
		input lock_request_ch1, lock_request_ch2, fieldbus_present,
		input diag_input_valid, diag_input,
		output safe_out_ch1, safe_out_ch2,
		output signal_diag_output_valid, signal_diag_output
	);
	modport ctl (
		output lock_request_ch1, lock_request_ch2, fieldbus_present,
		output diag_input_valid, diag_input,
		input safe_out_ch1, safe_out_ch2,
		input signal_diag_output_valid, signal_diag_output
	);
endinterface

// [glk_tick.sv]
`timescale 1ns/1ps
module glk_tick #(
	parameter int unsigned TICK_CYC = glk_pkg::MS_TICK_CYC
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	output logic o_tick
);
	localparam int TW = glk_pkg::TICK_W;
	localparam logic [TW-1:0] LAST = TW'(TICK_CYC - 1);

	logic [TW-1:0] cnt_q;
	wire logic wrap = (cnt_q == LAST);

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			cnt_q <= '0;
			o_tick <= 1'b0;
		end else begin
			cnt_q <= wrap ? '0 : cnt_q + TW'(1);
			o_tick <= wrap;
		end
	end
endmodule // glk_tick

// [glk_device.sv]
`timescale 1ns/1ps
module glk_device #(
	parameter int unsigned TICK_CYC = glk_pkg::MS_TICK_CYC
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	glk_if.dev bus,
	input wire logic i_actuator_detected,
	input wire logic i_pin_locked,
	input wire logic i_aux_released,
	input wire logic i_directional,
	output logic o_lock_cmd,
	output logic o_warning,
	output logic [1:0] o_mode
);
	localparam int MW = glk_pkg::MS_W;

	typedef enum logic [1:0] {
		P_IDLE,
		P_WAIT2,
		P_HOLD,
		P_DONE
	} glk_pair_t;

	// ****************************************************************
	// state
	// ****************************************************************
	logic tick;
	logic ch1_q;
	logic ch2_q;
	glk_pair_t pair_q;
	glk_pair_t pair_d;
	logic first1_q;
	logic [MW-1:0] ms_q;
	logic [MW-1:0] ms_d;
	logic lock_q;
	logic lock_d;
	glk_pkg::glk_mode_t mode_q;
	glk_pkg::glk_mode_t mode_d;
	logic pend_q;
	logic pend_lock_q;
	logic [MW-1:0] wait_q;
	logic safe_q;
	logic warn_q;
	logic rep_valid_q;
	logic [7:0] rep_q;

	glk_tick #(
		.TICK_CYC(TICK_CYC)
	) u_tick (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.o_tick(tick)
	);

	// ****************************************************************
	// request edge decoding
	// ****************************************************************
	wire logic ch1 = bus.lock_request_ch1;
	wire logic ch2 = bus.lock_request_ch2;
	wire logic rise1 = ch1 & ~ch1_q;
	wire logic rise2 = ch2 & ~ch2_q;
	wire logic both_high = ch1 & ch2;
	wire logic both_low = ~ch1 & ~ch2;
	wire logic ms_inc = tick & (ms_q != glk_pkg::MS_MAX);
	wire logic same_rise = (pair_q == P_IDLE) & rise1 & rise2;
	wire logic second_rise = (pair_q == P_WAIT2) & (first1_q ? rise2 : rise1);
	wire logic first_lost = (pair_q == P_WAIT2) & (first1_q ? ~ch1 : ~ch2);
	wire logic dir_ok = second_rise & (ms_q >= glk_pkg::DIR_MIN_MS)
		& (ms_q <= glk_pkg::DIR_MAX_MS);
	wire logic dir_lock = i_directional & dir_ok & first1_q;
	wire logic dir_unlock = i_directional & dir_ok & ~first1_q;
	// near-simultaneous edges arm a toggle pulse
	wire logic tog_arm = ~i_directional & (same_rise | (second_rise
		& (ms_q < glk_pkg::TOGGLE_MAX_MS)));
	wire logic width_ok = (ms_q >= glk_pkg::PULSE_MIN_MS)
		& (ms_q <= glk_pkg::PULSE_MAX_MS);
	wire logic hold_end = (pair_q == P_HOLD) & ~both_high;
	wire logic tog_fire = hold_end & width_ok;
	wire logic wait_late = (pair_q == P_WAIT2)
		& (ms_q > glk_pkg::DIR_MAX_MS);

	always_comb begin
		pair_d = pair_q;
		ms_d = ms_inc ? ms_q + glk_pkg::MS_ONE : ms_q;
		case (pair_q)
			P_IDLE: begin
				// both low: nothing starts
				if (same_rise) begin
					pair_d = tog_arm ? P_HOLD : P_DONE;
					ms_d = '0;
				end else if (rise1 | rise2) begin
					pair_d = P_WAIT2;
					ms_d = '0;
				end
			end
			P_WAIT2: begin
				if (second_rise) begin
					pair_d = tog_arm ? P_HOLD : P_DONE;
					ms_d = '0;
				end else if (first_lost) begin
					pair_d = P_IDLE;
				end else if (wait_late) begin
					pair_d = P_DONE;
				end
			end
			P_HOLD: begin
				if (hold_end | (ms_q > glk_pkg::PULSE_MAX_MS)) begin
					pair_d = P_DONE;
				end
			end
			P_DONE: begin
				if (both_low) begin
					pair_d = P_IDLE;
				end
			end
			default: begin
				pair_d = P_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			ch1_q <= 1'b0;
			ch2_q <= 1'b0;
			pair_q <= P_IDLE;
			ms_q <= '0;
			first1_q <= 1'b0;
		end else begin
			ch1_q <= ch1;
			ch2_q <= ch2;
			pair_q <= pair_d;
			ms_q <= ms_d;
			if ((pair_q == P_IDLE) & (rise1 | rise2)) begin
				first1_q <= rise1;
			end
		end
	end

	// ****************************************************************
	// diagnostic bus and operating modes
	// ****************************************************************
	// bus words count only while a fieldbus module is attached
	wire logic cmd_in = bus.fieldbus_present & bus.diag_input_valid;
	wire logic [7:0] cmd = bus.diag_input;
	wire logic active = (mode_q == glk_pkg::MODE_ACTIVE);
	wire logic edge_mode = ~active;
	wire logic bus_lock = cmd_in & active & (cmd == glk_pkg::CMD_LOCK);
	wire logic bus_unlock = cmd_in & active & (cmd == glk_pkg::CMD_UNLOCK);
	wire logic pend_late = pend_q & (wait_q > glk_pkg::DIAG_WAIT_MS);
	wire logic act_apply = pend_q & ~pend_late & both_high;

	always_comb begin
		mode_d = mode_q;
		// mode words are accepted straight after restart
		if (cmd_in) begin
			case (cmd)
				glk_pkg::CMD_MODE_NONE: mode_d = glk_pkg::MODE_NONE;
				glk_pkg::CMD_MODE_PASSIVE: mode_d = glk_pkg::MODE_PASSIVE;
				glk_pkg::CMD_MODE_ACTIVE: mode_d = glk_pkg::MODE_ACTIVE;
				default: mode_d = mode_q;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			mode_q <= glk_pkg::MODE_NONE;
			pend_q <= 1'b0;
			pend_lock_q <= 1'b0;
			wait_q <= '0;
		end else begin
			mode_q <= mode_d;
			if (bus_lock | bus_unlock) begin
				pend_q <= 1'b1;
				pend_lock_q <= bus_lock;
				wait_q <= '0;
			end else if (act_apply | pend_late | ~active) begin
				pend_q <= 1'b0;
			end else if (tick & pend_q) begin
				wait_q <= wait_q + glk_pkg::MS_ONE;
			end
		end
	end

	// ****************************************************************
	// lock state and safety outputs
	// ****************************************************************
	wire logic do_toggle = edge_mode & tog_fire;
	wire logic do_lock = (edge_mode & dir_lock) | (act_apply & pend_lock_q);
	wire logic do_unlock = (edge_mode & dir_unlock)
		| (act_apply & ~pend_lock_q);

	always_comb begin
		lock_d = lock_q;
		// decisions land in the next clock, far inside the 100 ms budget
		if (i_aux_released) begin
			lock_d = lock_q;
		end else if (do_toggle) begin
			lock_d = ~lock_q;
		end else if (do_lock) begin
			lock_d = 1'b1;
		end else if (do_unlock) begin
			lock_d = 1'b0;
		end
	end

	wire logic safe_d = i_actuator_detected & i_pin_locked
		& ~i_aux_released;
	wire logic report = ~edge_mode | (mode_q == glk_pkg::MODE_PASSIVE);
	wire logic [7:0] status = {2'h0, mode_q, ~i_aux_released & lock_q,
		i_aux_released, safe_q, lock_q};

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			lock_q <= 1'b0;
			safe_q <= 1'b0;
			warn_q <= 1'b0;
			rep_valid_q <= 1'b0;
			rep_q <= 8'h00;
		end else begin
			lock_q <= lock_d;
			safe_q <= safe_d;
			warn_q <= i_aux_released;
			// replies only while reporting and a module is attached
			rep_valid_q <= report & bus.fieldbus_present
				& (cmd_in | (lock_d != lock_q));
			rep_q <= status;
		end
	end

	assign bus.safe_out_ch1 = safe_q;
	assign bus.safe_out_ch2 = safe_q;
	assign bus.signal_diag_output_valid = rep_valid_q;
	assign bus.signal_diag_output = rep_q;
	assign o_lock_cmd = lock_q;
	assign o_warning = warn_q;
	assign o_mode = mode_q;
endmodule // glk_device

// [glk_controller.sv]
`timescale 1ns/1ps
module glk_controller #(
	parameter int unsigned TICK_CYC = glk_pkg::MS_TICK_CYC
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	glk_if.ctl bus,
	input wire logic i_fieldbus_present,
	input wire logic i_plant_safe,
	input wire logic i_motion_done,
	input wire logic i_directional,
	input wire logic i_active_diag,
	input wire logic i_req_lock,
	input wire logic i_req_unlock,
	input wire logic i_req_toggle,
	input wire logic i_diag_valid,
	input wire logic [7:0] i_diag_cmd,
	output logic o_busy,
	output logic o_guard_safe,
	output logic o_status_valid,
	output logic [7:0] o_status
);
	localparam int MW = glk_pkg::MS_W;

	typedef enum logic [2:0] {
		C_IDLE,
		C_CMD,
		C_LEAD,
		C_BOTH,
		C_GAP
	} glk_cst_t;

	logic tick;
	glk_cst_t st_q;
	glk_cst_t st_d;
	logic [MW-1:0] ms_q;
	logic lead1_q;
	logic ch1_q;
	logic ch2_q;
	logic dv_q;
	logic [7:0] dc_q;
	logic present_q;
	logic safe_q;
	logic sv_q;
	logic [7:0] s_q;

	glk_tick #(
		.TICK_CYC(TICK_CYC)
	) u_tick (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.o_tick(tick)
	);

	// ****************************************************************
	// request sequencing
	// ****************************************************************
	// release only after motion, any request only in a safe plant
	wire logic want_unlock = i_req_unlock & i_motion_done;
	wire logic want_tog = i_req_toggle & ~i_directional & ~i_active_diag;
	wire logic start = (st_q == C_IDLE) & i_plant_safe
		& (i_req_lock | want_unlock | want_tog);
	wire logic act_start = start & i_active_diag & ~want_tog;
	wire logic dir_start = start & ~i_active_diag & i_directional;
	wire logic ms_done_lead = ms_q >= glk_pkg::DIR_OFFSET_MS;
	wire logic ms_done_pulse = ms_q >= glk_pkg::PULSE_NOM_MS;
	wire logic ms_done_gap = ms_q >= glk_pkg::GAP_MS;

	always_comb begin
		st_d = st_q;
		case (st_q)
			C_IDLE: begin
				if (act_start) begin
					st_d = C_CMD;
				end else if (dir_start) begin
					st_d = C_LEAD;
				end else if (start) begin
					st_d = C_BOTH;
				end
			end
			C_CMD: begin
				// raise both one tick after the command
				if (tick) begin
					st_d = C_BOTH;
				end
			end
			C_LEAD: begin
				if (ms_done_lead) begin
					st_d = C_BOTH;
				end
			end
			C_BOTH: begin
				if (ms_done_pulse) begin
					st_d = C_GAP;
				end
			end
			C_GAP: begin
				if (ms_done_gap) begin
					st_d = C_IDLE;
				end
			end
			default: begin
				st_d = C_IDLE;
			end
		endcase
	end

	// the lead flag of the last request must not drive ch1 at start
	wire logic ch1_d = (st_d == C_BOTH) | ((st_d == C_LEAD) & lead1_q
		& (st_q != C_IDLE)) | ((st_d == C_LEAD) & (st_q == C_IDLE)
		& ~want_unlock);
	wire logic ch2_d = (st_d == C_BOTH) | ((st_d == C_LEAD) & ~lead1_q
		& (st_q != C_IDLE)) | ((st_d == C_LEAD) & (st_q == C_IDLE)
		& want_unlock);

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			st_q <= C_IDLE;
			ms_q <= '0;
			lead1_q <= 1'b0;
			ch1_q <= 1'b0;
			ch2_q <= 1'b0;
			dv_q <= 1'b0;
			dc_q <= 8'h00;
			present_q <= 1'b0;
			safe_q <= 1'b0;
			sv_q <= 1'b0;
			s_q <= 8'h00;
		end else begin
			st_q <= st_d;
			if (st_d != st_q) begin
				ms_q <= '0;
			end else if (tick & (ms_q != glk_pkg::MS_MAX)) begin
				ms_q <= ms_q + glk_pkg::MS_ONE;
			end
			if (start) begin
				lead1_q <= ~want_unlock;
			end
			ch1_q <= ch1_d;
			ch2_q <= ch2_d;
			dv_q <= act_start | (i_diag_valid & ~start);
			dc_q <= act_start ? (want_unlock ? glk_pkg::CMD_UNLOCK
				: glk_pkg::CMD_LOCK) : i_diag_cmd;
			present_q <= i_fieldbus_present;
			safe_q <= bus.safe_out_ch1 & bus.safe_out_ch2;
			sv_q <= bus.signal_diag_output_valid;
			s_q <= bus.signal_diag_output;
		end
	end

	assign bus.lock_request_ch1 = ch1_q;
	assign bus.lock_request_ch2 = ch2_q;
	assign bus.fieldbus_present = present_q;
	assign bus.diag_input_valid = dv_q & present_q;
	assign bus.diag_input = dc_q;
	assign o_busy = st_q != C_IDLE;
	assign o_guard_safe = safe_q;
	assign o_status_valid = sv_q;
	assign o_status = s_q;
endmodule // glk_controller

// [glk_properties.sv]
`timescale 1ns/1ps
module glk_properties #(
	parameter int unsigned TICK_CYC = glk_pkg::MS_TICK_CYC
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic lock_request_ch1,
	input wire logic lock_request_ch2,
	input wire logic safe_out_ch1,
	input wire logic safe_out_ch2,
	input wire logic fieldbus_present,
	input wire logic diag_input_valid,
	input wire logic [7:0] diag_input,
	input wire logic signal_diag_output_valid,
	input wire logic [7:0] signal_diag_output
);
	// ********
	// request timing in clock cycles
	// ********
	localparam int MS = int'(TICK_CYC);
	localparam int PMIN = int'(glk_pkg::PULSE_MIN_MS) * MS;
	localparam int PMAX = int'(glk_pkg::PULSE_MAX_MS) * MS;
	localparam int DMIN = int'(glk_pkg::DIR_MIN_MS) * MS;
	localparam int DMAX = int'(glk_pkg::DIR_MAX_MS) * MS;
	localparam int WMAX = int'(glk_pkg::DIAG_WAIT_MS) * MS;
	logic both, one, cmd, seen_q, seen_d;
	int both_q, both_d, lead_q, lead_d, wait_q, wait_d;
	assign both = lock_request_ch1 & lock_request_ch2;
	assign one = lock_request_ch1 ^ lock_request_ch2;
	assign cmd = diag_input_valid & fieldbus_present
		& (diag_input[7:1] == glk_pkg::CMD_LOCK[7:1]);
	assign both_d = (both && !i_sys_rst) ? both_q + 1 : 0;
	assign lead_d = (one && !i_sys_rst) ? lead_q + 1 : 0;
	// cycles a bus lock or unlock command waits for both requests
	assign wait_d = ((wait_q > 0 || cmd) && !both && !i_sys_rst)
		? wait_q + 1 : 0;
	assign seen_d = !i_sys_rst
		&& (seen_q || (diag_input_valid && fieldbus_present));
	always_ff @(posedge i_clk) begin
		both_q <= both_d;
		lead_q <= lead_d;
		wait_q <= wait_d;
		seen_q <= seen_d;
	end
	default clocking dc @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	sequence s_pair_end;
		both ##1 (!lock_request_ch1 && !lock_request_ch2);
	endsequence
	sequence s_second_rise;
		one ##1 both;
	endsequence
	safe_pair_a: assert property (safe_out_ch1 == safe_out_ch2)
		else $error("safe outputs differ");
	pulse_max_a: assert property (both_q <= PMAX)
		else $error("request pulse too long");
	pulse_min_a: assert property (s_pair_end |-> both_q >= PMIN)
		else $error("request pulse too short");
	lead_window_a: assert property (s_second_rise |->
		lead_q >= DMIN && lead_q <= DMAX)
		else $error("edge spacing out of window");
	pair_gap_a: assert property (s_pair_end |=>
		(!lock_request_ch1 && !lock_request_ch2) [*8])
		else $error("requests not returned low");
	raise_wait_a: assert property (wait_q <= WMAX)
		else $error("requests late after bus command");
	reply_bus_a: assert property (signal_diag_output_valid |->
		$past(fieldbus_present))
		else $error("reply without fieldbus module");
	reply_mode_a: assert property (signal_diag_output_valid |->
		seen_q && signal_diag_output[5:4] != 2'h0)
		else $error("reply outside diagnostic mode");
endmodule // glk_properties

// [glk_bench.sv]
`timescale 1ns/1ps
module glk_bench;
	localparam int TC = 4;
	typedef struct packed {
		logic d;
		logic f;
		logic [9:0] lead;
		logic [9:0] hi;
		logic e;
	} glk_row_t;
	// direction, ch2 first, lead ms, high ms, expected lock
	localparam glk_row_t ROWS [8] = '{
		'{1'b0, 1'b0, 10'h000, 10'h177, 1'b1},
		'{1'b0, 1'b1, 10'h00a, 10'h177, 1'b0},
		'{1'b0, 1'b0, 10'h000, 10'h12c, 1'b0},
		'{1'b0, 1'b0, 10'h01e, 10'h177, 1'b0},
		'{1'b1, 1'b0, 10'h01e, 10'h177, 1'b0},
		'{1'b1, 1'b0, 10'h064, 10'h177, 1'b1},
		'{1'b1, 1'b1, 10'h208, 10'h064, 1'b1},
		'{1'b1, 1'b1, 10'h064, 10'h177, 1'b0}};
	// direction, lock, unlock, toggle, expected lock
	localparam logic [4:0] CROWS [6] = '{5'h03, 5'h02, 5'h19, 5'h19, 5'h14, 5'h19};
	logic i_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic act = 1'b1, aux = 1'b0, dir = 1'b0, dir2 = 1'b0, fb = 1'b0;
	logic done = 1'b1;
	logic any_req;
	logic safe = 1'b1, adiag = 1'b0, rl = 1'b0, ru = 1'b0, rt = 1'b0, dv = 1'b0;
	logic [7:0] dc = 8'h00;
	logic busy, gsafe, sv, lock, lock2, warn;
	logic [7:0] st;
	logic [1:0] mode;
	int n_errors = 0;
	int samples_checked = 0;
	glk_if lnk();
	glk_if lnk2();
	always #20 i_clk = ~i_clk;
	assign any_req = lnk.lock_request_ch1 | lnk.lock_request_ch2;
	glk_controller #(.TICK_CYC(TC)) glk_controller_inst (.i_clk(i_clk),
		.i_sys_rst(i_sys_rst), .bus(lnk), .i_fieldbus_present(fb),
		.i_plant_safe(safe), .i_motion_done(done), .i_directional(dir),
		.i_active_diag(adiag), .i_req_lock(rl), .i_req_unlock(ru),
		.i_req_toggle(rt), .i_diag_valid(dv), .i_diag_cmd(dc), .o_busy(busy),
		.o_guard_safe(gsafe), .o_status_valid(sv), .o_status(st));
	glk_device #(.TICK_CYC(TC)) glk_device_inst (.i_clk(i_clk),
		.i_sys_rst(i_sys_rst), .bus(lnk), .i_actuator_detected(act),
		.i_pin_locked(lock), .i_aux_released(aux), .i_directional(dir),
		.o_lock_cmd(lock), .o_warning(warn), .o_mode(mode));
	// second device faces the bench driver for malformed requests
	glk_device #(.TICK_CYC(TC)) glk_device_inst_b (.i_clk(i_clk),
		.i_sys_rst(i_sys_rst), .bus(lnk2), .i_actuator_detected(1'b1),
		.i_pin_locked(lock2), .i_aux_released(1'b0), .i_directional(dir2),
		.o_lock_cmd(lock2), .o_warning(), .o_mode());
	glk_properties #(.TICK_CYC(TC)) glk_properties_inst (.i_clk(i_clk),
		.i_sys_rst(i_sys_rst), .lock_request_ch1(lnk.lock_request_ch1),
		.lock_request_ch2(lnk.lock_request_ch2),
		.safe_out_ch1(lnk.safe_out_ch1), .safe_out_ch2(lnk.safe_out_ch2),
		.fieldbus_present(lnk.fieldbus_present),
		.diag_input_valid(lnk.diag_input_valid), .diag_input(lnk.diag_input),
		.signal_diag_output_valid(lnk.signal_diag_output_valid),
		.signal_diag_output(lnk.signal_diag_output));
	// ********
	// tasks
	// ********
	task automatic chk(input string nm, input logic [7:0] seen,
		input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic idle;
		int k;
		k = 0;
		while (busy !== 1'b0 && k < 8000) begin
			@(negedge i_clk);
			k++;
		end
		chk("busy", busy, 8'h00);
	endtask
	task automatic req(input logic [2:0] r);
		int k;
		@(negedge i_clk);
		{rl, ru, rt} = r;
		k = 0;
		while (busy !== 1'b1 && k < 200) begin
			@(negedge i_clk);
			k++;
		end
		{rl, ru, rt} = 3'h0;
		idle();
	endtask
	task automatic cmd(input logic [7:0] c, input logic exp);
		logic got;
		got = 1'b0;
		@(negedge i_clk);
		dv = 1'b1;
		dc = c;
		@(negedge i_clk);
		dv = 1'b0;
		repeat (6) begin
			@(negedge i_clk);
			got = got | sv;
		end
		chk("reply", got, exp);
	endtask
	task automatic pair2(input glk_row_t r);
		dir2 = r.d;
		@(negedge i_clk);
		if (r.f) lnk2.lock_request_ch2 = 1'b1;
		else lnk2.lock_request_ch1 = 1'b1;
		repeat (int'(r.lead) * TC) @(negedge i_clk);
		if (r.f) lnk2.lock_request_ch1 = 1'b1;
		else lnk2.lock_request_ch2 = 1'b1;
		repeat (int'(r.hi) * TC) @(negedge i_clk);
		lnk2.lock_request_ch1 = 1'b0;
		lnk2.lock_request_ch2 = 1'b0;
		repeat (100 * TC) @(negedge i_clk);
	endtask
	// one bus word to the second device, valid low again before the next
	task automatic word2(input logic [7:0] c);
		@(negedge i_clk);
		lnk2.diag_input = c;
		lnk2.diag_input_valid = 1'b1;
		@(negedge i_clk);
		lnk2.diag_input_valid = 1'b0;
	endtask
	task automatic finish_test;
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// ********
	// sequence
	// ********
	initial begin
		#3_600_000;
		n_errors++;
		finish_test();
	end
	initial begin
		lnk2.lock_request_ch1 = 1'b0;
		lnk2.lock_request_ch2 = 1'b0;
		lnk2.fieldbus_present = 1'b0;
		lnk2.diag_input_valid = 1'b0;
		lnk2.diag_input = 8'h00;
		repeat (20) @(negedge i_clk);
		i_sys_rst = 1'b0;
		@(negedge i_clk);
		chk("lock", lock, 8'h00);
		chk("mode", mode, 8'h00);
		chk("safe", gsafe, 8'h00);
		foreach (CROWS[i]) begin
			dir = CROWS[i][4];
			req(CROWS[i][3:1]);
			chk("lock", lock, CROWS[i][0]);
			chk("safe", gsafe, CROWS[i][0]);
		end
		foreach (ROWS[i]) begin
			pair2(ROWS[i]);
			chk("lock2", lock2, ROWS[i].e);
		end
		// active mode: a bus command alone and edges alone change nothing
		lnk2.fieldbus_present = 1'b1;
		word2(glk_pkg::CMD_MODE_ACTIVE);
		word2(glk_pkg::CMD_LOCK);
		repeat (600 * TC) @(negedge i_clk);
		chk("lock2", lock2, 8'h00);
		pair2(ROWS[5]);
		chk("lock2", lock2, 8'h00);
		word2(glk_pkg::CMD_MODE_NONE);
		pair2(ROWS[5]);
		chk("lock2", lock2, 8'h01);
		aux = 1'b1;
		repeat (4) @(negedge i_clk);
		chk("safe", lnk.safe_out_ch1, 8'h00);
		chk("warn", warn, 8'h01);
		req(3'h2);
		chk("lock", lock, 8'h01);
		aux = 1'b0;
		act = 1'b0;
		repeat (4) @(negedge i_clk);
		chk("safe", lnk.safe_out_ch2, 8'h00);
		act = 1'b1;
		repeat (4) @(negedge i_clk);
		chk("safe", lnk.safe_out_ch2, 8'h01);
		fb = 1'b1;
		cmd(glk_pkg::CMD_POLL, 1'b0);
		cmd(glk_pkg::CMD_MODE_PASSIVE, 1'b0);
		chk("mode", mode, 8'h01);
		cmd(glk_pkg::CMD_POLL, 1'b1);
		chk("status", st, 8'h1b);
		fb = 1'b0;
		cmd(glk_pkg::CMD_POLL, 1'b0);
		fb = 1'b1;
		req(3'h2);
		chk("lock", lock, 8'h00);
		adiag = 1'b1;
		cmd(glk_pkg::CMD_MODE_ACTIVE, 1'b1);
		chk("mode", mode, 8'h02);
		req(3'h4);
		chk("lock", lock, 8'h01);
		cmd(glk_pkg::CMD_POLL, 1'b1);
		req(3'h2);
		idle();
		chk("lock", lock, 8'h00);
		adiag = 1'b0;
		dir = 1'b0;
		safe = 1'b0;
		rt = 1'b1;
		repeat (50) @(negedge i_clk);
		chk("request", any_req, 8'h00);
		rt = 1'b0;
		safe = 1'b1;
		done = 1'b0;
		ru = 1'b1;
		repeat (50) @(negedge i_clk);
		chk("request", any_req, 8'h00);
		ru = 1'b0;
		done = 1'b1;
		idle();
		finish_test();
	end
endmodule // glk_bench
